// >>> hw/iof_params.svh
// Constants for the indexed-offset fill-ones execution block
// Notes on behaviour
// - Indexed offset accepted only from 0 to 95
// - Write FFh at pointer two plus offset
// - Status flags and pointer register stay untouched
// - Opcode upper byte 0110 1000, low byte offset
// - One word, completes in one instruction cycle
// - Decode, read offset, process, write in Q1-Q4
// - Indexed mode only when extended bit is one
`ifndef IOF_PARAMS_SVH
`define IOF_PARAMS_SVH

// ----------------------------------------------------------------
// Encoding and data
// ----------------------------------------------------------------
`define IOF_OPCODE_HI 8'h68
`define IOF_FILL_VALUE 8'hFF
`define IOF_OFFSET_MAX 8'h5F
`define IOF_EXT_ON 1'h1

// ----------------------------------------------------------------
// Ordinary access-bank mapping
// ----------------------------------------------------------------
`define IOF_ACCESS_SPLIT 8'h60
`define IOF_ACCESS_LOW_PAGE 4'h0
`define IOF_ACCESS_HIGH_PAGE 4'hF

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOF_CLOCK_PERIOD_NS 100
`define IOF_PHASES_PER_CYCLE 4

`endif

// >>> hw/iof_pkg.sv
// Types shared by the fill-ones execution block
package iof_pkg;

  // Four phases of one instruction cycle
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} iof_phase_t;

  // Instruction word as handed over by the core decoder
  typedef struct packed {
    logic [7:0] opHi; // Opcode byte
    logic [7:0] offset; // Literal offset byte
  } iof_instr_t;

  // Data-memory write port
  typedef struct packed {
    logic en; // Write strobe, one cycle
    logic [11:0] addr; // Byte address
    logic [7:0] data; // Byte written
  } iof_mem_wr_t;

endpackage : iof_pkg

// >>> hw/iof_phase_gen.sv
// Four-phase sequencer splitting the instruction cycle
module iof_phase_gen (
  input wire logic clock, // System clock
  input wire logic rstN, // Synchronised reset, active low
  output iof_pkg::iof_phase_t phase // Current phase
);

  // ----------------------------------------------------------------
  // Phase register
  // ----------------------------------------------------------------
  iof_pkg::iof_phase_t phase_reg; // Current phase
  iof_pkg::iof_phase_t phase_next; // Following phase

  // Steps Q1 to Q4 and wraps
  always_comb
  begin
    unique case (phase_reg)
      iof_pkg::PH_Q1: phase_next = iof_pkg::PH_Q2;
      iof_pkg::PH_Q2: phase_next = iof_pkg::PH_Q3;
      iof_pkg::PH_Q3: phase_next = iof_pkg::PH_Q4;
      iof_pkg::PH_Q4: phase_next = iof_pkg::PH_Q1;
    endcase
  end

  // Starts in Q1 after reset
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
      phase_reg <= iof_pkg::PH_Q1;
    else
      phase_reg <= phase_next;
  end

  assign phase = phase_reg;

endmodule // iof_phase_gen

// >>> hw/iof_fill_ones.sv
// Execution of the indexed fill-ones instruction
`include "iof_params.svh"

module iof_fill_ones (
  input wire logic clock, // System clock, 10 MHz
  input wire logic arst_n, // Asynchronous reset, active low
  input wire logic instrValid, // Decoder presents a word in Q1
  input wire logic [15:0] instrWord, // Instruction word
  input wire logic extSetEnable, // Extended set configuration bit
  input wire logic [11:0] pointerTwo, // Indirect pointer two contents
  output iof_pkg::iof_phase_t phase, // Current phase
  output iof_pkg::iof_mem_wr_t memWr, // Data-memory write port
  output logic offsetReject, // Indexed offset out of range, Q4 pulse
  output logic instrDone, // Instruction completed, Q4 pulse
  output logic flagWrEn, // Status flag update, held low
  output logic pointerWrEn // Pointer register update, held low
);

  // ----------------------------------------------------------------
  // Reset synchroniser
  // ----------------------------------------------------------------
  logic rstMeta_reg; // First stage
  logic rstN_reg; // Released reset

  // Asserts at once, releases after two edges
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_reg <= 1'h0;
      rstN_reg <= 1'h0;
    end
    else
    begin
      rstMeta_reg <= 1'h1;
      rstN_reg <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------
  iof_phase_gen phaseGen (
    .clock(clock),
    .rstN(rstN_reg),
    .phase(phase)
  );

  // ----------------------------------------------------------------
  // Q1: decode
  // ----------------------------------------------------------------
  iof_pkg::iof_instr_t instr; // Word viewed as fields
  logic hit_reg; // Opcode matched in this cycle
  logic [7:0] word_reg; // Offset byte held from Q1

  assign instr = iof_pkg::iof_instr_t'(instrWord);

  // Match opcode byte while in Q1
  always_ff @(posedge clock or negedge rstN_reg)
  begin
    if (!rstN_reg)
    begin
      hit_reg <= 1'h0;
      word_reg <= 8'h00;
    end
    else if (phase == iof_pkg::PH_Q1)
    begin
      hit_reg <= instrValid && (instr.opHi == `IOF_OPCODE_HI);
      word_reg <= instr.offset;
    end
  end

  // ----------------------------------------------------------------
  // Q2: read offset and mode
  // ----------------------------------------------------------------
  logic [7:0] offset_reg; // Literal offset
  logic indexed_reg; // Indexed addressing in force

  // Latch offset and configuration in Q2
  always_ff @(posedge clock or negedge rstN_reg)
  begin
    if (!rstN_reg)
    begin
      offset_reg <= 8'h00;
      indexed_reg <= 1'h0;
    end
    else if (phase == iof_pkg::PH_Q2)
    begin
      offset_reg <= word_reg;
      indexed_reg <= (extSetEnable == `IOF_EXT_ON);
    end
  end

  // ----------------------------------------------------------------
  // Q3: process address
  // ----------------------------------------------------------------
  logic [11:0] addrIndexed; // Pointer plus offset
  logic [11:0] addrOrdinary; // Access-bank address
  logic inRange; // Offset within 0..95

  assign addrIndexed = pointerTwo + {4'h0, offset_reg};
  assign inRange = (offset_reg <= `IOF_OFFSET_MAX);

  // Low offsets hit low RAM, high ones the top page
  always_comb
  begin
    if (offset_reg < `IOF_ACCESS_SPLIT)
      addrOrdinary = {`IOF_ACCESS_LOW_PAGE, offset_reg};
    else
      addrOrdinary = {`IOF_ACCESS_HIGH_PAGE, offset_reg};
  end

  // ----------------------------------------------------------------
  // Q4: write
  // ----------------------------------------------------------------
  iof_pkg::iof_mem_wr_t memWr_reg; // Write port register
  logic reject_reg; // Out-of-range indication
  logic done_reg; // Completion indication

  // Set up at the Q3 edge so the strobe spans Q4
  always_ff @(posedge clock or negedge rstN_reg)
  begin
    if (!rstN_reg)
    begin
      memWr_reg <= '0;
      reject_reg <= 1'h0;
      done_reg <= 1'h0;
    end
    else if (phase == iof_pkg::PH_Q3)
    begin
      memWr_reg.data <= `IOF_FILL_VALUE;
      done_reg <= hit_reg;
      if (indexed_reg)
      begin
        memWr_reg.en <= hit_reg && inRange;
        memWr_reg.addr <= addrIndexed;
        reject_reg <= hit_reg && !inRange;
      end
      else
      begin
        memWr_reg.en <= hit_reg;
        memWr_reg.addr <= addrOrdinary;
        reject_reg <= 1'h0;
      end
    end
    else
    begin
      memWr_reg.en <= 1'h0;
      reject_reg <= 1'h0;
      done_reg <= 1'h0;
    end
  end

  assign memWr = memWr_reg;
  assign offsetReject = reject_reg;
  assign instrDone = done_reg;
  assign flagWrEn = 1'h0;
  assign pointerWrEn = 1'h0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_write_in_q4;
    @(posedge clock) disable iff (!rstN_reg)
      memWr.en |-> phase == iof_pkg::PH_Q4;
  endproperty
  a_write_in_q4: assert property (p_write_in_q4) else $error("write outside Q4");

  property p_fill_value;
    @(posedge clock) disable iff (!rstN_reg)
      memWr.en |-> memWr.data == 8'hFF;
  endproperty
  a_fill_value: assert property (p_fill_value) else $error("written byte not FFh");

  property p_indexed_write;
    @(posedge clock) disable iff (!rstN_reg)
      (phase == iof_pkg::PH_Q1 && instrValid && instrWord[15:8] == 8'h68 && instrWord[7:0] <= 8'h5F)
      ##1 extSetEnable ##1 1'b1
      |=> memWr.en && memWr.addr == 12'($past(pointerTwo) + {4'h0, $past(offset_reg)});
  endproperty
  a_indexed_write: assert property (p_indexed_write) else $error("indexed write missing");

  property p_range_reject;
    @(posedge clock) disable iff (!rstN_reg)
      (phase == iof_pkg::PH_Q1 && instrValid && instrWord[15:8] == 8'h68 && instrWord[7:0] > 8'h5F)
      ##1 extSetEnable |-> ##2 offsetReject && !memWr.en;
  endproperty
  a_range_reject: assert property (p_range_reject) else $error("out-of-range offset written");

  property p_ordinary_mode;
    @(posedge clock) disable iff (!rstN_reg)
      (phase == iof_pkg::PH_Q1 && instrValid && instrWord[15:8] == 8'h68)
      ##1 !extSetEnable |-> ##2 memWr.en && memWr.addr[7:0] == $past(word_reg, 2) && !offsetReject;
  endproperty
  a_ordinary_mode: assert property (p_ordinary_mode) else $error("ordinary access wrong");

  property p_no_match;
    @(posedge clock) disable iff (!rstN_reg)
      (phase == iof_pkg::PH_Q1 && !(instrValid && instrWord[15:8] == 8'h68)) |-> ##3 !memWr.en && !instrDone;
  endproperty
  a_no_match: assert property (p_no_match) else $error("foreign word acted on");

  property p_single_cycle;
    @(posedge clock) disable iff (!rstN_reg)
      instrDone |=> !instrDone [*3];
  endproperty
  a_single_cycle: assert property (p_single_cycle) else $error("done more than once per cycle");

  property p_ext_gate;
    @(posedge clock) disable iff (!rstN_reg)
      offsetReject |-> $past(indexed_reg) && instrDone;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("reject without extended mode");

  property p_no_side_effect;
    @(posedge clock) disable iff (!rstN_reg)
      instrDone |-> !flagWrEn && !pointerWrEn;
  endproperty
  a_no_side_effect: assert property (p_no_side_effect) else $error("flags or pointer touched");

  c_indexed: cover property (@(posedge clock) disable iff (!rstN_reg) memWr.en && indexed_reg);
  c_ordinary: cover property (@(posedge clock) disable iff (!rstN_reg) memWr.en && !indexed_reg);
  c_reject: cover property (@(posedge clock) disable iff (!rstN_reg) offsetReject);
  c_back_to_back: cover property (@(posedge clock) disable iff (!rstN_reg) memWr.en ##4 memWr.en);

endmodule // iof_fill_ones

// >>> bench/iof_data_mem_model.sv
// Behavioural data memory behind the block's write port
module iof_data_mem_model (
  input wire logic clock, // System clock
  input iof_pkg::iof_mem_wr_t memWr, // Write port from the block
  input wire logic [11:0] peekAddr, // Read-back address
  output logic [7:0] peekData, // Byte held at peekAddr
  output int writeCount // Writes taken so far
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] memArray [4096]; // Whole data space, cleared to 00h
  // Clear the array so a stray write shows up
  initial
  begin
    writeCount = 0;
    foreach (memArray[i]) memArray[i] = 8'h00;
  end
  // Store the strobed byte at the edge ending Q4
  always @(posedge clock)
  begin
    if (memWr.en === 1'b1)
    begin
      memArray[memWr.addr] <= memWr.data;
      writeCount <= writeCount + 1;
    end
  end
  assign peekData = memArray[peekAddr];
endmodule // iof_data_mem_model

// >>> bench/iof_fill_ones_test.sv
// Self-checking bench for the indexed fill-ones block
module iof_fill_ones_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Row: word, ext, pointer, expected en, addr, reject, done
  typedef struct packed {
    logic [15:0] word; logic ext; logic [11:0] ptr;
    logic en; logic [11:0] addr; logic rej; logic done;
  } iof_row_t;
  logic clock = 1'b0, arst_n = 1'b0, instrValid = 1'b0, extSetEnable = 1'b0; // Drives
  logic [15:0] instrWord = 16'h0000; // Word to the block
  logic [11:0] pointerTwo = 12'h000, peekAddr = 12'h000, lastAddr = 12'h000; // Addresses
  logic lastWr = 1'b0; // Previous instruction wrote
  iof_pkg::iof_phase_t phase; // Phase seen
  iof_pkg::iof_mem_wr_t memWr; // Write port seen
  logic offsetReject, instrDone, flagWrEn, pointerWrEn; // Pulses and idles
  logic [7:0] peekData; // Model read-back
  int writeCount, wrExp = 0, fail_count = 0, checks = 0; // Counters
  iof_row_t rows [7] = '{
    '{16'h682C, 1'b1, 12'hA00, 1'b1, 12'hA2C, 1'b0, 1'b1},
    '{16'h685F, 1'b1, 12'hFF0, 1'b1, 12'h04F, 1'b0, 1'b1},
    '{16'h6860, 1'b1, 12'h100, 1'b0, 12'h000, 1'b1, 1'b1},
    '{16'h6810, 1'b0, 12'hA00, 1'b1, 12'h010, 1'b0, 1'b1},
    '{16'h6870, 1'b0, 12'hA00, 1'b1, 12'hF70, 1'b0, 1'b1},
    '{16'h6900, 1'b1, 12'hA00, 1'b0, 12'h000, 1'b0, 1'b0},
    '{16'h6860, 1'b0, 12'hA00, 1'b1, 12'hF60, 1'b0, 1'b1}};
  // 10 MHz clock
  initial
  begin
    forever #50 clock = ~clock;
  end
  iof_fill_ones u_iof_fill_ones (.clock(clock), .arst_n(arst_n), .instrValid(instrValid),
    .instrWord(instrWord), .extSetEnable(extSetEnable), .pointerTwo(pointerTwo), .phase(phase),
    .memWr(memWr), .offsetReject(offsetReject), .instrDone(instrDone), .flagWrEn(flagWrEn),
    .pointerWrEn(pointerWrEn));
  iof_data_mem_model u_iof_data_mem_model (.clock(clock), .memWr(memWr), .peekAddr(peekAddr),
    .peekData(peekData), .writeCount(writeCount));
  // One comparison, reported at once
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask
  // Verdict and end of run
  task finish_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Return at the edge that starts a Q1 cycle
  task automatic sync;
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (phase !== iof_pkg::PH_Q4 && n < 8);
    if (n >= 8)
    begin
      fail_count++;
      finish_test();
    end
  endtask
  // One instruction cycle, entered at the edge starting Q1
  task automatic exec(input iof_row_t r);
    instrValid <= 1'b1;
    instrWord <= r.word;
    extSetEnable <= r.ext;
    pointerTwo <= r.ptr;
    peekAddr <= lastAddr;
    @(posedge clock);
    instrValid <= 1'b0;
    @(negedge clock);
    if (lastWr) check("memByte", 16'h00FF, peekData);
    check("writes", wrExp[15:0], writeCount[15:0]);
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("phase", iof_pkg::PH_Q4, phase);
    check("en", r.en, memWr.en);
    if (r.en) check("addr", r.addr, memWr.addr);
    if (r.en) check("data", 16'h00FF, memWr.data);
    check("reject", r.rej, offsetReject);
    check("done", r.done, instrDone);
    check("flags", 16'h0000, {flagWrEn, pointerWrEn});
    lastWr = r.en;
    lastAddr = r.addr;
    wrExp += r.en;
    @(posedge clock);
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clock);
    @(negedge clock);
    check("rstPhase", iof_pkg::PH_Q1, phase);
    check("rstEn", 16'h0000, memWr.en);
    @(posedge clock);
    arst_n <= 1'b1;
    sync();
    // Table rows, back to back in consecutive Q1s
    foreach (rows[i]) exec(rows[i]);
    // Matching word shown outside Q1 is ignored
    @(posedge clock);
    instrValid <= 1'b1;
    instrWord <= 16'h6801;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("lateDone", 16'h0000, instrDone);
    check("lateEn", 16'h0000, memWr.en);
    @(posedge clock);
    exec(rows[0]);
    exec(rows[5]);
    // Reset at the start of Q3 cancels the pending write
    instrValid <= 1'b1;
    instrWord <= 16'h6805;
    extSetEnable <= 1'b1;
    @(posedge clock);
    instrValid <= 1'b0;
    @(posedge clock);
    arst_n <= 1'b0;
    @(negedge clock);
    check("midRstPhase", iof_pkg::PH_Q1, phase);
    check("midRstEn", 16'h0000, {memWr.en, instrDone});
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    check("relPhase", iof_pkg::PH_Q1, phase);
    check("relEn", 16'h0000, {memWr.en, instrDone, offsetReject});
    sync();
    exec(rows[1]);
    finish_test();
  end
endmodule // iof_fill_ones_test
